// ---- sfpe_program_engine.sv ----
// Purpose: page and sequential program handling of a serial flash
// Assumes: spi modes 0/3, spiClk stands still outside frames
// Notes:   array writes go out on memWr, verify result on memFail
`timescale 1ns/1ps
`include "sfpe_params.svh"

module sfpe_program_engine #(
	parameter int PAGE_PROGRAM_CYCLES = `SFPE_PAGE_PROG_US * 1000 / `SFPE_REF_CLK_NS,
	parameter int BYTE_PROGRAM_CYCLES = `SFPE_BYTE_PROG_US * 1000 / `SFPE_REF_CLK_NS
) (
	input  wire logic                       ref_clk,
	input  wire logic                       reset_n,
	input  wire logic                       spiClk,
	input  wire logic                       csN,
	input  wire logic                       mosi,
	input  wire logic [`SFPE_SECTORS-1:0]   sectorProtect,
	input  wire logic                       memFail,
	output sfpe_pkg::sfpe_mem_wr_t          memWr,
	output sfpe_pkg::sfpe_status_t          status
);

	// ------------------------------------------------------------
	// link domain: byte assembly
	// ------------------------------------------------------------
	logic [6:0] shiftIn;
	logic [2:0] bitCnt;
	logic [7:0] byteHold;
	logic       byteToggle;
	logic       midByte;

	always_ff @(posedge spiClk or posedge csN) begin
		if (csN) begin
			shiftIn <= 7'h00;
			bitCnt  <= 3'h0;
		end else begin
			shiftIn <= {shiftIn[5:0], mosi};
			bitCnt  <= bitCnt + 3'h1;
		end
	end

	always_ff @(posedge spiClk or negedge reset_n) begin
		if (!reset_n) begin
			byteHold   <= 8'h00;
			byteToggle <= 1'b0;
		end else if (!csN && bitCnt == 3'h7) begin
			byteHold   <= {shiftIn, mosi};
			byteToggle <= ~byteToggle;
		end
	end

	// position of the last bit, kept over chip select release
	always_ff @(posedge spiClk or negedge reset_n) begin
		if (!reset_n)
			midByte <= 1'b0;
		else if (!csN)
			midByte <= (bitCnt != 3'h7);
	end

	// ------------------------------------------------------------
	// crossings into the reference domain
	// ------------------------------------------------------------
	logic [3:0] csSync;
	logic [2:0] togSync;
	logic       alignSyncA;
	logic       alignSyncB;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			csSync     <= 4'hF;
			togSync    <= 3'h0;
			alignSyncA <= 1'b0;
			alignSyncB <= 1'b0;
		end else begin
			csSync     <= {csSync[2:0], csN};
			togSync    <= {togSync[1:0], byteToggle};
			alignSyncA <= midByte;
			alignSyncB <= alignSyncA;
		end
	end

	logic byteStrobe;
	logic frameStart;
	logic frameEnd;
	logic aligned;

	assign byteStrobe = togSync[1] ^ togSync[2];
	assign frameStart = !csSync[2] && csSync[3];
	assign frameEnd   = csSync[2] && !csSync[3];
	assign aligned    = !alignSyncB;

	// ------------------------------------------------------------
	// frame decode
	// ------------------------------------------------------------
	sfpe_pkg::sfpe_state_t state;
	logic [2:0]               byteCnt;
	logic [7:0]               opcode;
	logic [`SFPE_ADDR_W-1:0]  frameAddr;
	logic [7:0]               lastData;
	logic [7:0]               wrPtr;
	logic                     captureOk;
	logic                     write_enable_latch;
	logic                     seqMode;
	logic [`SFPE_ADDR_W-1:0]  seqAddr;
	logic                     isPage;
	logic                     isSeq;

	assign isPage = (opcode == `SFPE_OP_PAGE_PROG);
	assign isSeq  = (opcode == `SFPE_OP_SEQ_A) || (opcode == `SFPE_OP_SEQ_B);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			byteCnt   <= 3'h0;
			opcode    <= 8'h00;
			frameAddr <= '0;
			lastData  <= `SFPE_ERASED_BYTE;
			wrPtr     <= 8'h00;
			captureOk <= 1'b0;
		end else if (frameStart) begin
			byteCnt <= 3'h0;
		end else if (byteStrobe) begin
			if (byteCnt != `SFPE_CNT_FIRST_DATA)
				byteCnt <= byteCnt + 3'h1;
			unique case (byteCnt)
				3'h0: begin
					opcode    <= byteHold;
					captureOk <= (state == sfpe_pkg::SFPE_IDLE);
				end
				3'h1: begin
					frameAddr[20:16] <= byteHold[4:0];
					lastData         <= byteHold;
				end
				3'h2: begin
					frameAddr[15:8] <= byteHold;
					lastData        <= byteHold;
				end
				3'h3: begin
					frameAddr[7:0] <= byteHold;
					wrPtr          <= byteHold;
					lastData       <= byteHold;
				end
				default: begin
					lastData <= byteHold;
					wrPtr    <= wrPtr + 8'h01;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// frame end decisions
	// ------------------------------------------------------------
	logic                     startPage;
	logic                     startSeq;
	logic                     setWel;
	logic                     clrWel;
	logic                     exitSeq;
	logic [`SFPE_ADDR_W-1:0]  seqTarget;
	logic                     targetProt;

	assign seqTarget  = seqMode ? seqAddr + 21'h000001 : frameAddr;
	assign targetProt = sectorProtect[frameAddr[20:`SFPE_SECTOR_LSB]];

	always_comb begin
		startPage = 1'b0;
		startSeq  = 1'b0;
		setWel    = 1'b0;
		clrWel    = 1'b0;
		exitSeq   = 1'b0;
		if (frameEnd && captureOk && byteCnt != 3'h0) begin
			if (opcode == `SFPE_OP_WR_ENABLE) begin
				setWel = aligned;
			end else if (opcode == `SFPE_OP_WR_DISABLE) begin
				clrWel  = aligned;
				exitSeq = aligned;
			end else if (isPage && !seqMode && write_enable_latch) begin
				if (aligned && byteCnt == `SFPE_CNT_FIRST_DATA && !targetProt)
					startPage = 1'b1;
				else
					clrWel = 1'b1;
			end else if (isSeq && seqMode) begin
				if (aligned && byteCnt != `SFPE_CNT_OPCODE) begin
					startSeq = 1'b1;
				end else begin
					clrWel  = 1'b1;
					exitSeq = 1'b1;
				end
			end else if (isSeq && write_enable_latch) begin
				if (aligned && byteCnt == `SFPE_CNT_FIRST_DATA && !targetProt)
					startSeq = 1'b1;
				else
					clrWel = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// page buffer
	// ------------------------------------------------------------
	logic [7:0]                  pageBuf [`SFPE_PAGE_BYTES];
	logic [`SFPE_PAGE_BYTES-1:0] pageValid;
	logic                        bufWrite;

	assign bufWrite = byteStrobe && !frameStart && captureOk && isPage && !seqMode
		&& byteCnt >= `SFPE_CNT_ADDR_DONE;

	always_ff @(posedge ref_clk) begin
		if (bufWrite)
			pageBuf[wrPtr] <= byteHold;
		else if (startSeq)
			pageBuf[seqTarget[7:0]] <= lastData;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pageValid <= '0;
		end else if (byteStrobe && byteCnt == 3'h0 && state == sfpe_pkg::SFPE_IDLE) begin
			pageValid <= '0;
		end else if (bufWrite) begin
			pageValid[wrPtr] <= 1'b1;
		end else if (startSeq) begin
			pageValid                  <= '0;
			pageValid[seqTarget[7:0]] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// program sequencer
	// ------------------------------------------------------------
	logic [`SFPE_ADDR_W-9:0]  progBase;
	logic [8:0]               walkPtr;
	logic [`SFPE_TIMER_W-1:0] timer;
	logic                     exitAfter;
	logic                     progDone;

	assign progDone = (state == sfpe_pkg::SFPE_WAIT) && timer == '0;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state    <= sfpe_pkg::SFPE_IDLE;
			progBase <= '0;
			walkPtr  <= 9'h000;
			timer    <= '0;
		end else begin
			unique case (state)
				sfpe_pkg::SFPE_IDLE: begin
					walkPtr <= 9'h000;
					if (startPage) begin
						progBase <= frameAddr[20:8];
						timer    <= `SFPE_TIMER_W'(PAGE_PROGRAM_CYCLES);
						state    <= sfpe_pkg::SFPE_WRITE;
					end else if (startSeq) begin
						progBase <= seqTarget[20:8];
						timer    <= `SFPE_TIMER_W'(BYTE_PROGRAM_CYCLES);
						state    <= sfpe_pkg::SFPE_WRITE;
					end
				end
				sfpe_pkg::SFPE_WRITE: begin
					walkPtr <= walkPtr + 9'h001;
					if (timer != '0)
						timer <= timer - `SFPE_TIMER_W'(1);
					if (walkPtr == 9'h0FF)
						state <= sfpe_pkg::SFPE_WAIT;
				end
				sfpe_pkg::SFPE_WAIT: begin
					if (timer != '0)
						timer <= timer - `SFPE_TIMER_W'(1);
					else
						state <= sfpe_pkg::SFPE_IDLE;
				end
				default: state <= sfpe_pkg::SFPE_IDLE;
			endcase
		end
	end

	// array writes, only buffered locations touched
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			memWr <= '0;
		end else begin
			memWr.we   <= (state == sfpe_pkg::SFPE_WRITE) && pageValid[walkPtr[7:0]];
			memWr.addr <= {progBase, walkPtr[7:0]};
			memWr.data <= pageBuf[walkPtr[7:0]];
		end
	end

	// ------------------------------------------------------------
	// latch, mode and error flags
	// ------------------------------------------------------------
	logic errFlag;
	logic lastOrProt;

	assign lastOrProt = (seqTarget == `SFPE_LAST_ADDR)
		|| ((&seqTarget[`SFPE_SECTOR_LSB-1:0])
		&& sectorProtect[seqTarget[20:`SFPE_SECTOR_LSB] + 5'h01]);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			write_enable_latch <= 1'b0;
		end else if (setWel) begin
			write_enable_latch <= 1'b1;
		end else if (clrWel || startPage || (progDone && exitAfter)) begin
			write_enable_latch <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			seqMode   <= 1'b0;
			seqAddr   <= '0;
			exitAfter <= 1'b0;
		end else if (startSeq) begin
			seqMode   <= 1'b1;
			seqAddr   <= seqTarget;
			exitAfter <= lastOrProt;
		end else if (exitSeq || (progDone && exitAfter)) begin
			seqMode   <= 1'b0;
			exitAfter <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			errFlag <= 1'b0;
		else if (memWr.we && memFail)
			errFlag <= 1'b1;
		else if (startPage || startSeq)
			errFlag <= 1'b0;
	end

	assign status.busy                  = (state != sfpe_pkg::SFPE_IDLE);
	assign status.writeEnableLatch      = write_enable_latch;
	assign status.programEraseErrorFlag = errFlag;
	assign status.seqMode               = seqMode;

endmodule : sfpe_program_engine

// ---- sfpe_params.svh ----
// Purpose: constants of the serial flash program engine
// Assumes: reference clock of 125 MHz
// Notes:   offsets, opcodes and timing figures as macros
`ifndef SFPE_PARAMS_SVH
`define SFPE_PARAMS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFPE_OP_PAGE_PROG   8'h02
`define SFPE_OP_SEQ_A       8'hAD
`define SFPE_OP_SEQ_B       8'hAF
`define SFPE_OP_WR_ENABLE   8'h06
`define SFPE_OP_WR_DISABLE  8'h04

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define SFPE_ADDR_W         21
`define SFPE_PAGE_BYTES     256
`define SFPE_ERASED_BYTE    8'hFF
`define SFPE_LAST_ADDR      21'h1FFFFF
`define SFPE_SECTOR_LSB     16
`define SFPE_SECTORS        32

// ----------------------------------------------------------------
// frame byte counts
// ----------------------------------------------------------------
`define SFPE_CNT_OPCODE     3'h1
`define SFPE_CNT_ADDR_DONE  3'h4
`define SFPE_CNT_FIRST_DATA 3'h5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SFPE_REF_CLK_NS     8
`define SFPE_PAGE_PROG_US   1000
`define SFPE_BYTE_PROG_US   7
`define SFPE_TIMER_W        18

`endif

// ---- sfpe_pkg.sv ----
// Purpose: types of the serial flash program engine
// Assumes: sfpe_params.svh holds the numbers
// Notes:   nothing here is imported; use sfpe_pkg::name
package sfpe_pkg;

	// ------------------------------------------------------------
	// program sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SFPE_IDLE  = 3'b001,
		SFPE_WRITE = 3'b010,
		SFPE_WAIT  = 3'b100
	} sfpe_state_t;

	// ------------------------------------------------------------
	// array write port
	// ------------------------------------------------------------
	typedef struct packed {
		logic        we;
		logic [20:0] addr;
		logic [7:0]  data;
	} sfpe_mem_wr_t;

	// ------------------------------------------------------------
	// status bits
	// ------------------------------------------------------------
	typedef struct packed {
		logic busy;
		logic writeEnableLatch;
		logic programEraseErrorFlag;
		logic seqMode;
	} sfpe_status_t;

endpackage : sfpe_pkg

// ---- sfpe_program_engine_assertions.sv ----
// Purpose: port assertions of the program engine
// Assumes: bound into sfpe_program_engine, one ref_clk domain
// Notes:   busy length held in a helper counter
`timescale 1ns/1ps
`include "sfpe_params.svh"
module sfpe_program_engine_assertions #(
	parameter int PAGE_PROGRAM_CYCLES = 300,
	parameter int BYTE_PROGRAM_CYCLES = 300
) (
	input wire logic                     ref_clk,
	input wire logic                     reset_n,
	input wire logic [`SFPE_SECTORS-1:0] sectorProtect,
	input wire logic                     memFail,
	input sfpe_pkg::sfpe_mem_wr_t        memWr,
	input sfpe_pkg::sfpe_status_t        status
);
	localparam int BUSY_MAX = (PAGE_PROGRAM_CYCLES > BYTE_PROGRAM_CYCLES ?
		PAGE_PROGRAM_CYCLES : BYTE_PROGRAM_CYCLES) + 1;
	int busyCnt;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			busyCnt <= 0;
		else
			busyCnt <= status.busy ? busyCnt + 1 : 0;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_busy_end;
		status.busy ##1 !status.busy;
	endsequence
	sequence s_wr_pair;
		memWr.we ##1 memWr.we;
	endsequence
	chk_reset_clear: assert property (!$past(reset_n) |-> status == '0 && !memWr.we)
		else $error("state not clear after reset");
	chk_wr_unprot: assert property (memWr.we |-> !sectorProtect[memWr.addr[20:16]])
		else $error("write into protected sector");
	chk_wr_busy: assert property (memWr.we |-> status.busy)
		else $error("array write while not busy");
	chk_page_step: assert property (s_wr_pair |-> memWr.addr == $past(memWr.addr) + 21'h1
		&& memWr.addr[20:8] == $past(memWr.addr[20:8]))
		else $error("page write left its page");
	chk_err_cause: assert property ($rose(status.programEraseErrorFlag)
		|-> $past(memFail) && $past(memWr.we))
		else $error("error flag without failed write");
	chk_done_latch: assert property (s_busy_end |-> !status.writeEnableLatch || status.seqMode)
		else $error("latch still set after program");
	chk_seq_latch: assert property ($rose(status.seqMode) |-> status.writeEnableLatch)
		else $error("sequential mode without latch");
	chk_busy_refuse: assert property (status.busy && $past(status.busy)
		|-> !$rose(status.writeEnableLatch))
		else $error("latch set while busy");
	chk_busy_bound: assert property (status.busy |-> busyCnt <= BUSY_MAX)
		else $error("busy held too long");
	chk_seq_exit: assert property ($fell(status.seqMode) |-> !status.writeEnableLatch)
		else $error("latch still set after leaving sequential mode");
endmodule : sfpe_program_engine_assertions

bind sfpe_program_engine sfpe_program_engine_assertions #(
	.PAGE_PROGRAM_CYCLES(PAGE_PROGRAM_CYCLES),
	.BYTE_PROGRAM_CYCLES(BYTE_PROGRAM_CYCLES)
) chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .sectorProtect(sectorProtect),
	.memFail(memFail), .memWr(memWr), .status(status));

// ---- sfpe_spi_host.sv ----
// Purpose: spi host model driving frames into the engine
// Assumes: mode 0, 64 ns serial clock only inside frames
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/1ps
module sfpe_spi_host (
	output logic spiClk,
	output logic csN,
	output logic mosi
);
	initial begin
		spiClk = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
	end
	task automatic frame(input logic [7:0] b[$], input int extra);
		logic [7:0] v;
		#3.3;
		csN = 1'b0;
		for (int i = 0; i < b.size() * 8 + extra; i++) begin
			v = (i / 8 < b.size()) ? b[i / 8] : 8'hA5;
			mosi = v[7 - i % 8];
			#32 spiClk = 1'b1;
			#32 spiClk = 1'b0;
		end
		#32 csN = 1'b1;
		mosi = ~mosi;
		#100;
	endtask : frame
endmodule : sfpe_spi_host

// ---- test_serial_flash_program_engine.sv ----
// Purpose: self-checking bench of the program engine
// Assumes: short program times of 300 cycles
// Notes:   behavioural model predicts writes and flags per frame
`timescale 1ns/1ps
`include "sfpe_params.svh"
module test_serial_flash_program_engine;
	logic                   ref_clk = 1'b0;
	logic                   reset_n = 1'b0;
	logic [31:0]            sectorProtect = 32'h00000002;
	logic                   memFail = 1'b0;
	wire                    spiClk, csN, mosi;
	sfpe_pkg::sfpe_mem_wr_t memWr;
	sfpe_pkg::sfpe_status_t status;
	logic [28:0]            got[$], expq[$];
	logic [7:0]             pb[256];
	bit                     pv[256];
	bit                     write_enable_latch, seq, err;
	logic [20:0]            seqAddr;
	int                     n_mismatch, n_compared;
	always #4 ref_clk = ~ref_clk;
	sfpe_spi_host host_u (.spiClk(spiClk), .csN(csN), .mosi(mosi));
	sfpe_program_engine #(.PAGE_PROGRAM_CYCLES(300), .BYTE_PROGRAM_CYCLES(300)) dut_u (
		.ref_clk(ref_clk), .reset_n(reset_n), .spiClk(spiClk), .csN(csN), .mosi(mosi),
		.sectorProtect(sectorProtect), .memFail(memFail), .memWr(memWr), .status(status));
	always @(posedge ref_clk) if (memWr.we === 1'b1) got.push_back({memWr.addr, memWr.data});
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	task automatic cmp_flag(input string name, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", name, e, g);
		end
	endtask : cmp_flag
	task automatic cmp_wr(input string name, input logic [28:0] e, input logic [28:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask : cmp_wr
	task automatic model(input logic [7:0] q[$], input int extra);
		logic [20:0] a;
		bit ok;
		int n;
		ok = extra == 0;
		expq.delete();
		a = (q.size() > 3) ? {q[1][4:0], q[2], q[3]} : 21'h0;
		if (ok && q[0] == `SFPE_OP_WR_ENABLE)
			write_enable_latch = 1;
		else if (ok && q[0] == `SFPE_OP_WR_DISABLE) begin
			write_enable_latch = 0;
			seq = 0;
		end else if (q[0] == `SFPE_OP_PAGE_PROG && write_enable_latch && !seq) begin
			write_enable_latch = 0;
			if (ok && q.size() > 4 && !sectorProtect[a[20:16]]) begin
				pv = '{default: 0};
				for (int k = 4; k < q.size(); k++) begin
					n = (a[7:0] + k - 4) % 256;
					pb[n] = q[k];
					pv[n] = 1;
				end
				for (int o = 0; o < 256; o++)
					if (pv[o]) expq.push_back({a[20:8], o[7:0], pb[o]});
			end
		end else if ((q[0] == `SFPE_OP_SEQ_A || q[0] == `SFPE_OP_SEQ_B) && (write_enable_latch || seq)) begin
			n = seq ? 1 : 4;
			if (seq) a = seqAddr;
			if (!ok || q.size() <= n || (!seq && sectorProtect[a[20:16]])) begin
				write_enable_latch = 0;
				seq = 0;
			end else begin
				expq.push_back({a, q[q.size() - 1]});
				seqAddr = a + 21'h1;
				seq = !(a == `SFPE_LAST_ADDR || sectorProtect[seqAddr[20:16]]);
				write_enable_latch = seq;
			end
		end
		if (expq.size() > 0) err = memFail;
	endtask : model
	task automatic run(input logic [7:0] q[$], input int extra);
		model(q, extra);
		got.delete();
		host_u.frame(q, extra);
		repeat (8) @(posedge ref_clk);
		cmp_flag("busy", expq.size() > 0, status.busy);
		for (int i = 0; i < 1000 && status.busy !== 1'b0; i++) @(posedge ref_clk);
		cmp_flag("idle", 1'b0, status.busy);
		cmp_flag("write count", 1'b1, got.size() == expq.size());
		foreach (expq[i]) if (i < got.size()) cmp_wr("write", expq[i], got[i]);
		cmp_flag("latch", write_enable_latch, status.writeEnableLatch);
		cmp_flag("seq mode", seq, status.seqMode);
		cmp_flag("error flag", err, status.programEraseErrorFlag);
	endtask : run
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] q[$];
		logic [20:0] sa[2];
		void'($urandom(32'hEB00));
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		cmp_flag("reset status", 1'b1, status === 4'h0);
		run('{8'h02, 8'h00, 8'h01, 8'h00, 8'h5A}, 0);
		run('{8'h06}, 0);
		q = '{8'h02, 8'h00, 8'h00, 8'hFE};
		repeat (3) q.push_back(8'($urandom));
		run(q, 0);
		run('{8'h06}, 0);
		q = '{8'h02, 8'h1F, 8'h00, 8'h10};
		repeat (258) q.push_back(8'($urandom));
		run(q, 0);
		run('{8'h06}, 0);
		run('{8'h02, 8'h00, 8'h03}, 0);
		run('{8'h06}, 0);
		run('{8'h02, 8'h00, 8'h03, 8'h00, 8'h11}, 3);
		run('{8'h06}, 0);
		run('{8'h02, 8'h01, 8'h00, 8'h00, 8'h11}, 0);
		memFail <= 1'b1;
		run('{8'h06}, 0);
		run('{8'h02, 8'h02, 8'h00, 8'h00, 8'h3C}, 0);
		memFail <= 1'b0;
		run('{8'h06}, 0);
		run('{8'h02, 8'h02, 8'h00, 8'h01, 8'h3D}, 0);
		run('{8'hAD, 8'h00, 8'h40, 8'h00, 8'h22}, 0);
		sa = '{21'h00FFFE, 21'h1FFFFE};
		foreach (sa[i]) begin
			run('{8'h06}, 0);
			run('{8'hAD, {3'h0, sa[i][20:16]}, sa[i][15:8], sa[i][7:0], 8'($urandom)}, 0);
			run('{8'hAF, 8'($urandom), 8'($urandom)}, 0);
		end
		run('{8'h06}, 0);
		run('{8'hAD, 8'h00, 8'h50, 8'h00, 8'h44}, 0);
		run('{8'hAF, 8'h33}, 4);
		run('{8'h06}, 0);
		run('{8'hAF, 8'h00, 8'h60, 8'h00, 8'h55}, 0);
		run('{8'h04}, 0);
		run('{8'h06}, 0);
		run('{8'hAD, 8'h01, 8'h00, 8'h00, 8'h66}, 0);
		close_out();
	end
	initial begin
		#800000;
		n_mismatch++;
		close_out();
	end
endmodule : test_serial_flash_program_engine
